// >>> pswt_pkg.sv
// Constants, register map and types shared by the slave window translator
package pswt_pkg;

   // ****************************************************************
   // Window count and host base register layout
   // ****************************************************************
   localparam int         NUM_WIN   = 6;
   localparam int         BASE_LSB  = 4;
   localparam int         PF_BIT    = 3;
   localparam logic [1:0] KIND_MEM  = 2'h0;
   localparam logic       SIZE_32   = 1'b0;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [31:0] MASK_8MB_PF = 32'hff800008;
   localparam logic [31:0] MASK_4MB_NP = 32'hffc00000;
   localparam logic [NUM_WIN-1:0][31:0] MASK_RST = {MASK_8MB_PF, MASK_8MB_PF, MASK_8MB_PF,
                                                     MASK_4MB_NP, MASK_4MB_NP, MASK_8MB_PF};
   localparam logic [31:0] TRL_RST     = 32'h00000000;
   localparam logic [31:0] BAR_RST     = 32'h00000000;

   // ****************************************************************
   // Internal register offsets
   // ****************************************************************
   localparam logic [7:0] SYS_MASK_OFS  = 8'h00;
   localparam logic [7:0] SYS_TRL_OFS   = 8'h20;
   localparam logic [7:0] SYS_STAT_OFS  = 8'h40;
   localparam int         STAT_BUSY_BIT = 0;
   localparam int         STAT_DIRTY_BIT = 1;

   // ****************************************************************
   // Host configuration space offsets
   // ****************************************************************
   localparam logic [7:0] CFG_BAR_OFS  = 8'h10;
   localparam logic [7:0] CFG_MASK_OFS = 8'h40;
   localparam logic [7:0] CFG_TRL_OFS  = 8'h60;

   // ****************************************************************
   // Bounds for the crossings, in cycles of the waiting clock
   // ****************************************************************
   localparam int XFER_MAX_CYC = 60;

   typedef enum logic [1:0] {
      PUSH_IDLE = 2'b01,
      PUSH_WAIT = 2'b10
   } pswt_push_t;

   // Returns {hit, index} for a word slot of a per-window register block
   function automatic logic [3:0] pswt_slot(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] off;
      off       = addr - base;
      pswt_slot = 4'h0;
      if (addr >= base && off[1:0] == 2'h0 && off[7:2] < 6'(NUM_WIN)) begin
         pswt_slot = {1'b1, off[4:2]};
      end
   endfunction

endpackage

// >>> pswt_window.sv
// PCI slave window registers, address decode and inbound address translation
// Functional notes
// - Six independent windows, each with base, mask and translation registers.
// - Base register holds base 31-4, prefetch bit 3, kind 2-1, size bit 0.
// - Kind field always reports memory space; I/O mapping unsupported.
// - Only 32-bit base registers; no 64-bit decoding.
// - Host writes reach base bits only where the mask bit is set.
// - Masks and translations writable by both sides; masks internally addressable.
// - Mask prefetch-enable bit shows as base register bit 3.
// - Address phase compares mask-selected upper bits; never fewer than four low bits.
// - Claim when any window matches; otherwise stay silent.
// - Internal bits 31-4 = (addr & ~mask) | (trl & mask); low bits pass.
`timescale 1ns/1ps
`default_nettype none
module pswt_window
   import pswt_pkg::*;
#(
   parameter int NWIN = NUM_WIN
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        sys_sel,
   input  wire logic        sys_we,
   input  wire logic [7:0]  sys_addr,
   input  wire logic [31:0] sys_wdata,
   output logic      [31:0] sys_rdata,
   output logic             sys_busy,
   input  wire logic        link_clk,
   input  wire logic        link_rst_n,
   input  wire logic        config_device_select,
   input  wire logic        cfg_we,
   input  wire logic        cfg_re,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_busy,
   input  wire logic        adr_valid,
   input  wire logic [31:0] adr,
   output logic             claim,
   output logic      [2:0]  claim_win,
   output logic      [31:0] local_addr
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   localparam logic [3:0] NWIN_L = 4'(NWIN);

   generate
      if (NWIN < 1 || NWIN > NUM_WIN) begin : g_bad_nwin
         $error("pswt_window: NWIN out of range");
      end
   endgenerate

   // ****************************************************************
   // State of both domains
   // ****************************************************************
   typedef struct packed {
      logic [NWIN-1:0][31:0] mask;
      logic [NWIN-1:0][31:0] trl;
      logic [NWIN-1:0][31:0] smask;
      logic [NWIN-1:0][31:0] strl;
      pswt_push_t            push;
      logic                  req;
      logic                  dirty;
      logic                  hseen;
      logic                  hreq_s1;
      logic                  hreq_s2;
      logic                  ack_s1;
      logic                  ack_s2;
      logic [31:0]           rdata;
   } pswt_sys_t;

   typedef struct packed {
      logic                  ce_s1;
      logic                  ce_s2;
      logic                  req_s1;
      logic                  req_s2;
      logic                  ack;
      logic [NWIN-1:0][31:0] mskc;
      logic [NWIN-1:0][31:0] trlc;
      logic [NWIN-1:0][31:0] bar;
      logic                  hreq;
      logic                  hack_s1;
      logic                  hack_s2;
      logic                  h_trl;
      logic [2:0]            h_idx;
      logic [31:0]           h_data;
      logic [31:0]           cfg_rdata;
      logic                  cfg_busy;
      logic                  claim;
      logic [2:0]            claim_win;
      logic [31:0]           local_addr;
   } pswt_link_t;

   function automatic pswt_sys_t sys_rst();
      pswt_sys_t r;
      r       = '0;
      r.push  = PUSH_IDLE;
      r.dirty = 1'b1;
      for (int i = 0; i < NWIN; i++) begin
         r.mask[i]  = MASK_RST[i];
         r.trl[i]   = TRL_RST;
         r.smask[i] = MASK_RST[i];
         r.strl[i]  = TRL_RST;
      end
      return r;
   endfunction

   function automatic pswt_link_t link_rst();
      pswt_link_t r;
      r = '0;
      for (int i = 0; i < NWIN; i++) begin
         r.mskc[i] = MASK_RST[i];
         r.trlc[i] = TRL_RST;
         r.bar[i]  = BAR_RST;
      end
      return r;
   endfunction

   localparam pswt_sys_t  SYS_RST  = sys_rst();
   localparam pswt_link_t LINK_RST = link_rst();

   pswt_sys_t  sq;
   pswt_sys_t  next_sq;
   pswt_link_t lq;
   pswt_link_t next_lq;

   logic [3:0]      s_msl;
   logic [3:0]      s_tsl;
   logic [3:0]      bsl;
   logic [3:0]      c_msl;
   logic [3:0]      c_tsl;
   logic            cfg_go;
   logic            pend;
   logic [NWIN-1:0] hit;
   logic [NWIN-1:0] below;
   logic            pf_sel;
   logic [31:0]     m_cw;
   logic [31:0]     t_cw;
   logic [31:0]     wm;

   // ****************************************************************
   // Internal side: mask and translation registers
   // ****************************************************************
   // The registers live here; the link side works from copies that a
   // toggle handshake refreshes, so the decoder never sees a torn word.
   always_comb begin
      next_sq = sq;
      s_msl   = pswt_slot(sys_addr, SYS_MASK_OFS);
      s_tsl   = pswt_slot(sys_addr, SYS_TRL_OFS);
      if (ce) begin
         next_sq.hreq_s1 = lq.hreq;
         next_sq.hreq_s2 = sq.hreq_s1;
         next_sq.ack_s1  = lq.ack;
         next_sq.ack_s2  = sq.ack_s1;
         next_sq.rdata   = 32'h0;
         case (sq.push)
            PUSH_IDLE: begin
               if (sq.dirty) begin
                  next_sq.smask = sq.mask;
                  next_sq.strl  = sq.trl;
                  next_sq.req   = ~sq.req;
                  next_sq.dirty = 1'b0;
                  next_sq.push  = PUSH_WAIT;
               end
            end
            PUSH_WAIT: begin
               if (sq.ack_s2 == sq.req) begin
                  next_sq.push = PUSH_IDLE;
               end
            end
            default: begin
               next_sq.push = PUSH_IDLE;
            end
         endcase
         // Host write request; its data stands still until acknowledged
         if (sq.hreq_s2 != sq.hseen) begin
            next_sq.hseen = sq.hreq_s2;
            next_sq.dirty = 1'b1;
            if (lq.h_trl) begin
               next_sq.trl[lq.h_idx] = lq.h_data;
            end else begin
               next_sq.mask[lq.h_idx] = lq.h_data;
            end
         end
         // Internal writes land after the host one, so they win a tie
         if (sys_sel) begin
            if (s_msl[3] && {1'b0, s_msl[2:0]} < NWIN_L) begin
               if (sys_we) begin
                  next_sq.mask[s_msl[2:0]] = sys_wdata;
                  next_sq.dirty            = 1'b1;
               end else begin
                  next_sq.rdata = sq.mask[s_msl[2:0]];
               end
            end else if (s_tsl[3] && {1'b0, s_tsl[2:0]} < NWIN_L) begin
               if (sys_we) begin
                  next_sq.trl[s_tsl[2:0]] = sys_wdata;
                  next_sq.dirty           = 1'b1;
               end else begin
                  next_sq.rdata = sq.trl[s_tsl[2:0]];
               end
            end else if (sys_addr == SYS_STAT_OFS && !sys_we) begin
               next_sq.rdata[STAT_BUSY_BIT]  = sq.push[1];
               next_sq.rdata[STAT_DIRTY_BIT] = sq.dirty;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sq <= SYS_RST;
      end else begin
         sq <= next_sq;
      end
   end

   // ****************************************************************
   // Link side: host base registers, configuration access, decode
   // ****************************************************************
   always_comb begin
      next_lq = lq;
      bsl     = pswt_slot(cfg_addr, CFG_BAR_OFS);
      c_msl   = pswt_slot(cfg_addr, CFG_MASK_OFS);
      c_tsl   = pswt_slot(cfg_addr, CFG_TRL_OFS);
      cfg_go  = config_device_select && cfg_addr[1:0] == 2'h0 && (cfg_we || cfg_re);
      pend    = lq.hreq != lq.hack_s2;
      pf_sel  = lq.mskc[bsl[2:0]][PF_BIT];
      m_cw    = lq.mskc[lq.claim_win];
      t_cw    = lq.trlc[lq.claim_win];
      wm      = {lq.mskc[bsl[2:0]][31:BASE_LSB], 4'h0};
      hit     = '0;
      below   = '0;
      for (int i = 0; i < NWIN; i++) begin
         // Low four bits never take part in the compare
         hit[i]   = (((adr[31:BASE_LSB] ^ lq.bar[i][31:BASE_LSB])
                     & lq.mskc[i][31:BASE_LSB]) == 28'h0);
         below[i] = 3'(i) < lq.claim_win;
      end
      next_lq.ce_s1 = ce;
      next_lq.ce_s2 = lq.ce_s1;
      if (lq.ce_s2) begin
         next_lq.req_s1    = sq.req;
         next_lq.req_s2    = lq.req_s1;
         next_lq.hack_s1   = sq.hseen;
         next_lq.hack_s2   = lq.hack_s1;
         next_lq.cfg_rdata = 32'h0;
         next_lq.claim     = 1'b0;
         if (lq.req_s2 != lq.ack) begin
            next_lq.mskc = sq.smask;
            next_lq.trlc = sq.strl;
            next_lq.ack  = lq.req_s2;
         end
         if (cfg_go) begin
            if (bsl[3] && {1'b0, bsl[2:0]} < NWIN_L) begin
               if (cfg_we) begin
                  next_lq.bar[bsl[2:0]] = (lq.bar[bsl[2:0]] & ~wm) | (cfg_wdata & wm);
               end else begin
                  // Kind reads memory space and size reads 32-bit, always
                  next_lq.cfg_rdata = {lq.bar[bsl[2:0]][31:BASE_LSB], pf_sel,
                                       KIND_MEM, SIZE_32};
               end
            end else if (c_msl[3] && {1'b0, c_msl[2:0]} < NWIN_L) begin
               if (cfg_we && !pend) begin
                  next_lq.h_trl  = 1'b0;
                  next_lq.h_idx  = c_msl[2:0];
                  next_lq.h_data = cfg_wdata;
                  next_lq.hreq   = ~lq.hreq;
               end else if (!cfg_we) begin
                  next_lq.cfg_rdata = lq.mskc[c_msl[2:0]];
               end
            end else if (c_tsl[3] && {1'b0, c_tsl[2:0]} < NWIN_L) begin
               if (cfg_we && !pend) begin
                  next_lq.h_trl  = 1'b1;
                  next_lq.h_idx  = c_tsl[2:0];
                  next_lq.h_data = cfg_wdata;
                  next_lq.hreq   = ~lq.hreq;
               end else if (!cfg_we) begin
                  next_lq.cfg_rdata = lq.trlc[c_tsl[2:0]];
               end
            end
         end
         // A second host write to a mask or translation is dropped while busy
         next_lq.cfg_busy = next_lq.hreq != lq.hack_s2;
         if (adr_valid) begin
            // Walk downward so the lowest matching window is kept
            for (int i = NWIN - 1; i >= 0; i--) begin
               if (hit[i]) begin
                  next_lq.claim      = 1'b1;
                  next_lq.claim_win  = 3'(i);
                  next_lq.local_addr = {(adr[31:BASE_LSB] & ~lq.mskc[i][31:BASE_LSB])
                                        | (lq.trlc[i][31:BASE_LSB] & lq.mskc[i][31:BASE_LSB]),
                                        adr[BASE_LSB-1:0]};
               end
            end
         end
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lq <= LINK_RST;
      end else begin
         lq <= next_lq;
      end
   end

   assign sys_rdata  = sq.rdata;
   assign sys_busy   = sq.push[1];
   assign cfg_rdata  = lq.cfg_rdata;
   assign cfg_busy   = lq.cfg_busy;
   assign claim      = lq.claim;
   assign claim_win  = lq.claim_win;
   assign local_addr = lq.local_addr;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Local copy, so the delay ranges name no package item
   localparam int XFER_LIM = XFER_MAX_CYC;

   sequence seq_addr_phase;
      lq.ce_s2 && adr_valid;
   endsequence

   sequence seq_bar_read;
      lq.ce_s2 && cfg_go && cfg_re && !cfg_we && bsl[3];
   endsequence

   sequence seq_sys_mask_wr;
      ce && sys_sel && sys_we && s_msl[3] && {1'b0, s_msl[2:0]} < NWIN_L;
   endsequence

   sequence seq_sys_same_rd;
      ce && sys_sel && !sys_we && sys_addr == $past(sys_addr);
   endsequence

   AST_SIX_WIN: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      claim |-> {1'b0, claim_win} < NWIN_L)
      else $error("claimed window index out of range");

   AST_BAR_FMT: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      seq_bar_read |=> (cfg_rdata[2:0] == 3'h0 && cfg_rdata[PF_BIT] == $past(pf_sel)))
      else $error("base register read shows wrong low bits");

   genvar gi;
   generate
      for (gi = 0; gi < NWIN; gi++) begin : g_ro
         AST_BAR_RO: assert property (@(posedge link_clk) disable iff (!link_rst_n)
            (((lq.bar[gi] ^ $past(lq.bar[gi])) & ~{$past(lq.mskc[gi][31:4]), 4'h0}) == 32'h0))
            else $error("base bit changed where mask is clear");
      end
   endgenerate

   AST_CLAIM: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      seq_addr_phase |=> (claim == ($past(hit) != '0)))
      else $error("claim does not follow window match");

   AST_LOWEST: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      claim |-> (($past(hit) & below) == '0))
      else $error("a lower window also matched");

   AST_XLATE: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      claim |-> (local_addr == {($past(adr[31:4]) & ~m_cw[31:4]) | (t_cw[31:4] & m_cw[31:4]),
                                $past(adr[3:0])}))
      else $error("translated address wrong");

   AST_HOST_DONE: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(cfg_busy) |-> ##[1:XFER_LIM] !cfg_busy)
      else $error("host register write never completed");

   AST_CFG_ALIGN: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (lq.ce_s2 && cfg_re && cfg_addr[1:0] != 2'h0) |=> cfg_rdata == 32'h0)
      else $error("misaligned configuration read answered");

   AST_SYS_RB: assert property (@(posedge clk_sys) disable iff (!rst_n)
      seq_sys_mask_wr ##1 seq_sys_same_rd |=> sys_rdata == $past(sys_wdata, 2))
      else $error("mask readback differs from write");

   AST_PUSH_DONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(sys_busy) |-> ##[1:XFER_LIM] !sys_busy)
      else $error("register copy to link side stalled");

endmodule
`default_nettype wire

// >>> pswt_host_model.sv
// Behavioural external bus host: free-running link clock, configuration accesses and address phases
`timescale 1ns/1ps
`default_nettype none
module pswt_host_model (
   output logic        link_clk,
   output logic        config_device_select,
   output logic        cfg_we,
   output logic        cfg_re,
   output logic [7:0]  cfg_addr,
   output logic [31:0] cfg_wdata,
   output logic        adr_valid,
   output logic [31:0] adr
);
   // ****************************************************************
   // Link clock and idle bus
   // ****************************************************************
   // The bus clock runs free; the odd offset keeps its edges off clk_sys edges
   initial begin
      config_device_select = 1'b0;
      cfg_we               = 1'b0;
      cfg_re               = 1'b0;
      cfg_addr             = 8'h00;
      cfg_wdata            = 32'h00000000;
      adr_valid            = 1'b0;
      adr                  = 32'h00000000;
      link_clk             = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   // ****************************************************************
   // One bus cycle: bit0 config write, bit1 config read, bit2 address phase
   // ****************************************************************
   // Released lines invert every cycle so stale values are never mistaken for data
   task automatic xfer(input logic [2:0] op, input logic [7:0] a, input logic [31:0] d);
      config_device_select <= |op[1:0];                  // Select only for config cycles
      cfg_we               <= op[0];
      cfg_re               <= op[1];
      cfg_addr             <= (|op[1:0]) ? a : ~cfg_addr; // Word aligned unless a test asks
      cfg_wdata            <= op[0] ? d : ~cfg_wdata;
      adr_valid            <= op[2];
      adr                  <= op[2] ? d : ~adr;
      @(posedge link_clk);
   endtask
endmodule
`default_nettype wire

// >>> pswt_window_tb.sv
// Self-checking testbench for the slave window translator
`timescale 1ns/1ps
`default_nettype none
module pswt_window_tb;
   import pswt_pkg::*;

   logic        clk_sys, rst_n, link_rst_n, ce, sys_sel, sys_we;
   logic [7:0]  sys_addr;
   logic [31:0] sys_wdata, sys_rdata, cfg_rdata, local_addr, cfg_wdata, adr;
   logic        sys_busy, link_clk, config_device_select, cfg_we, cfg_re, cfg_busy, adr_valid, claim;
   logic [7:0]  cfg_addr;
   logic [2:0]  claim_win;
   logic [31:0] msk [NUM_WIN];
   logic [31:0] trl [NUM_WIN];
   logic [31:0] bar [NUM_WIN];
   logic [35:0] q_sys[$];
   logic [35:0] q_cfg[$];
   logic [35:0] q_clm[$];
   logic        sys_pend = 1'b0;
   logic        cfg_pend = 1'b0;
   logic        adr_pend = 1'b0;
   int          n_errors = 0;
   int          compares = 0;

   pswt_window i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .sys_sel(sys_sel), .sys_we(sys_we),
      .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_busy(sys_busy),
      .link_clk(link_clk), .link_rst_n(link_rst_n), .config_device_select(config_device_select),
      .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_busy(cfg_busy), .adr_valid(adr_valid), .adr(adr), .claim(claim), .claim_win(claim_win),
      .local_addr(local_addr));

   pswt_host_model i_host (.link_clk(link_clk), .config_device_select(config_device_select), .cfg_we(cfg_we),
      .cfg_re(cfg_re), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .adr_valid(adr_valid), .adr(adr));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ****************************************************************
   // Reporting
   // ****************************************************************
   task automatic give_verdict();
      if (q_sys.size() + q_cfg.size() + q_clm.size() != 0) begin
         n_errors++;
         $display("BAD queues expected 0 seen 1");
      end
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ****************************************************************
   // Watchers: each answer takes the oldest note of its queue
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (sys_pend) chk("sys_rdata", q_sys.size() != 0 ? q_sys.pop_front() : 'x, {4'h0, sys_rdata}); // Regs
      sys_pend = sys_sel && !sys_we;
   end

   always @(posedge link_clk) begin
      if (cfg_pend) chk("cfg_rdata", q_cfg.size() != 0 ? q_cfg.pop_front() : 'x, {4'h0, cfg_rdata});
      if (adr_pend || claim) chk("claim", q_clm.size() != 0 ? q_clm.pop_front() : 'x,
         {claim, claim ? claim_win : 3'h0, claim ? local_addr : 32'h0});  // Decode
      cfg_pend = cfg_re;
      adr_pend = adr_valid;
   end

   // ****************************************************************
   // Reference decode and drivers
   // ****************************************************************
   function automatic logic [35:0] predict(input logic [31:0] a);
      predict = 36'h0;
      for (int n = NUM_WIN - 1; n >= 0; n--) begin
         if (((a[31:4] ^ bar[n][31:4]) & msk[n][31:4]) == 28'h0) begin               // Lowest wins
            predict = {1'b1, 3'(n), (a[31:4] & ~msk[n][31:4]) | (trl[n][31:4] & msk[n][31:4]), a[3:0]};
         end
      end
   endfunction

   task automatic sys_op(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d);
      sys_sel   <= op[1];
      sys_we    <= op[0];
      sys_addr  <= a;
      sys_wdata <= d;
      @(posedge clk_sys);
   endtask

   task automatic read_bar(input int k);
      q_cfg.push_back({4'h0, bar[k][31:4], msk[k][3], KIND_MEM, SIZE_32}); // Layout
      i_host.xfer(3'b010, CFG_BAR_OFS + 8'(4 * k), 32'h0);
   endtask

   task automatic write_bar(input int k, input logic [31:0] d);
      i_host.xfer(3'b001, CFG_BAR_OFS + 8'(4 * k), d);
      bar[k][31:4] = (bar[k][31:4] & ~msk[k][31:4]) | (d[31:4] & msk[k][31:4]); // Masked bits only
   endtask

   // Crossings have no done pulse, so wait for both busy flags under a bound
   task automatic settle();
      int i;
      repeat (8) @(posedge clk_sys);
      for (i = 0; i < 4 * XFER_MAX_CYC && (cfg_busy !== 1'b0 || sys_busy !== 1'b0); i++) @(posedge link_clk);
      if (i == 4 * XFER_MAX_CYC) begin
         n_errors++;
         $display("BAD busy expected 0 seen 1");
         give_verdict();
      end
      repeat (8) i_host.xfer(3'b000, 8'h00, 32'h0);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] m, d, a;
      int          k;
      rst_n      = 1'b0;
      link_rst_n = 1'b0;
      ce         = 1'b1;
      sys_sel    = 1'b0;
      sys_we     = 1'b0;
      sys_addr   = 8'h00;
      sys_wdata  = 32'h0;
      void'($urandom(32'hab1e));
      repeat (5) @(posedge clk_sys);
      rst_n      <= 1'b1;
      link_rst_n <= 1'b1;
      for (k = 0; k < NUM_WIN; k++) begin
         msk[k] = MASK_RST[k];
         trl[k] = TRL_RST;
         bar[k] = BAR_RST;
      end
      settle();
      ce <= 1'b0;
      sys_op(2'b11, SYS_TRL_OFS + 8'h14, 32'hffffffff); // Frozen while ce is low
      ce <= 1'b1;
      sys_op(2'b11, SYS_MASK_OFS, MASK_RST[0]);
      q_sys.push_back(36'h1 << STAT_DIRTY_BIT);
      sys_op(2'b10, SYS_STAT_OFS, 32'h0);
      q_sys.push_back(36'h1 << STAT_BUSY_BIT);
      sys_op(2'b10, SYS_STAT_OFS, 32'h0);
      for (k = 0; k < NUM_WIN; k++) begin                              // Reset values, six windows
         q_sys.push_back({4'h0, msk[k]});
         sys_op(2'b10, SYS_MASK_OFS + 8'(4 * k), 32'h0);
         q_sys.push_back({4'h0, trl[k]});
         sys_op(2'b10, SYS_TRL_OFS + 8'(4 * k), 32'h0);
      end
      q_sys.push_back(36'h0);
      sys_op(2'b10, 8'h80, 32'h0);                                     // Unmapped reads zero
      sys_op(2'b00, 8'h00, 32'h0);
      for (k = 0; k < NUM_WIN; k++) begin
         read_bar(k);
         write_bar(k, 32'hffffffff);                                   // Back to back write and read
         read_bar(k);
      end
      i_host.xfer(3'b001, CFG_BAR_OFS + 8'h01, 32'h0);                 // Misaligned write ignored
      q_cfg.push_back(36'h0);
      i_host.xfer(3'b010, CFG_BAR_OFS + 8'h02, 32'h0);                 // Misaligned read gives zero
      read_bar(0);
      d = $urandom;
      i_host.xfer(3'b001, CFG_TRL_OFS + 8'h0c, d);
      i_host.xfer(3'b001, CFG_TRL_OFS + 8'h0c, ~d);                    // Dropped while the first is pending
      i_host.xfer(3'b000, 8'h00, 32'h0);
      trl[3] = d;
      settle();
      q_cfg.push_back({4'h0, d});
      i_host.xfer(3'b010, CFG_TRL_OFS + 8'h0c, 32'h0);                 // Second write was dropped
      i_host.xfer(3'b000, 8'h00, 32'h0);
      for (int r = 0; r < 4; r++) begin
         for (k = 0; k < NUM_WIN; k++) begin                           // All masks before any base
            m = (32'hffffffff << (4 + $urandom_range(24, 0))) | {28'h0, 1'($urandom), 3'b000};
            msk[k] = m;
            trl[k] = $urandom;
            if (k % 2 == 1) begin                                      // Host side writes
               i_host.xfer(3'b001, CFG_MASK_OFS + 8'(4 * k), m);
               i_host.xfer(3'b000, 8'h00, 32'h0);
               settle();
               i_host.xfer(3'b001, CFG_TRL_OFS + 8'(4 * k), trl[k]);
               i_host.xfer(3'b000, 8'h00, 32'h0);
               settle();
            end else begin
               sys_op(2'b11, SYS_MASK_OFS + 8'(4 * k), m);
               q_sys.push_back({4'h0, m});
               sys_op(2'b10, SYS_MASK_OFS + 8'(4 * k), 32'h0);          // Readback right after write
               sys_op(2'b11, SYS_TRL_OFS + 8'(4 * k), trl[k]);
               sys_op(2'b00, 8'h00, 32'h0);
            end
         end
         settle();
         for (k = 0; k < NUM_WIN; k++) begin
            q_cfg.push_back({4'h0, msk[k]});                           // Host sees the mask
            i_host.xfer(3'b010, CFG_MASK_OFS + 8'(4 * k), 32'h0);
            write_bar(k, $urandom & 32'h3fffffff);
            read_bar(k);
         end
         for (int i = 0; i < 48; i++) begin
            k = $urandom_range(NUM_WIN - 1, 0);
            a = $urandom;
            if (i % 3 != 0) a = (bar[k] & {msk[k][31:4], 4'h0}) | (a & ~{msk[k][31:4], 4'h0});
            q_clm.push_back(predict(a));
            i_host.xfer(3'b100, 8'h00, a);                             // Back to back address phases
         end
         i_host.xfer(3'b000, 8'h00, 32'h0);
         for (k = 0; k < NUM_WIN; k++) begin                           // Both sides agree
            q_sys.push_back({4'h0, msk[k]});
            sys_op(2'b10, SYS_MASK_OFS + 8'(4 * k), 32'h0);
            q_sys.push_back({4'h0, trl[k]});
            sys_op(2'b10, SYS_TRL_OFS + 8'(4 * k), 32'h0);
         end
         sys_op(2'b00, 8'h00, 32'h0);
      end
      repeat (4) @(posedge clk_sys);
      give_verdict();
   end
endmodule
`default_nettype wire
